// *** shared/ebt_pkg.sv ***
// Package holding the constants and state types of the two 8-bit timer control blocks.
package ebt_pkg;

  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [15:0] EBT_ADDR_T0_CLOCK_SELECT = 16'hff6a;
  localparam logic [15:0] EBT_ADDR_T0_MODE_CTRL = 16'hff6b;
  localparam logic [15:0] EBT_ADDR_T1_CLOCK_SELECT = 16'hff8c;
  localparam logic [15:0] EBT_ADDR_T1_MODE_CTRL = 16'hff43;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] EBT_RST_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] EBT_RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] EBT_RST_COUNT = 8'h00;

  // ------------------------------------------------------------
  // Field positions of the mode control and clock select registers
  // ------------------------------------------------------------
  localparam int EBT_BIT_RUN = 7;
  localparam int EBT_BIT_PWM = 6;
  localparam int EBT_BIT_SET = 3;
  localparam int EBT_BIT_CLR = 2;
  localparam int EBT_BIT_INV = 1;
  localparam int EBT_BIT_OE = 0;
  localparam int EBT_CS_MSB = 2;

  // ------------------------------------------------------------
  // Clock select codes and divider exponents
  // ------------------------------------------------------------
  localparam logic [2:0] EBT_CS_EDGE_FALL = 3'h0;
  localparam logic [2:0] EBT_CS_EDGE_RISE = 3'h1;
  localparam logic [3:0] EBT_DIV_EXP_C2 = 4'h0;
  localparam logic [3:0] EBT_DIV_EXP_C3 = 4'h1;
  localparam logic [3:0] EBT_DIV_EXP_C5 = 4'h6;
  localparam logic [3:0] EBT_DIV_EXP_C6 = 4'h8;
  localparam logic [3:0] EBT_T0_DIV_EXP_C4 = 4'h2;
  localparam logic [3:0] EBT_T0_DIV_EXP_C7 = 4'hd;
  localparam logic [3:0] EBT_T1_DIV_EXP_C4 = 4'h4;
  localparam logic [3:0] EBT_T1_DIV_EXP_C7 = 4'hc;
  localparam int EBT_PSCL_W = 13;

  // ------------------------------------------------------------
  // State types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clk_sel;
    logic run;
    logic pwm;
    logic inv_pol;
    logic oe;
    logic out_ff;
    logic pwm_ff;
    logic [7:0] count;
    logic ev_sync1;
    logic ev_sync2;
    logic ev_prev;
    logic match_irq;
    logic tout;
  } ebt_chan_s;

  typedef struct packed {
    ebt_chan_s [1:0] ch;
    logic [EBT_PSCL_W-1:0] pscl;
    logic [7:0] rdata;
  } ebt_state_s;

endpackage

// *** src/ebt_timer_ctrl.sv ***
// Control registers, count clock selection and output logic of two 8-bit timer channels.
//
// Operation
// - Reset loads each clock select register with zero: event pin falling edge.
// - Channel 0 codes: fall, rise, clk, clk/2, /4, /64, /256, /8192.
// - Channel 1 matches channel 0 except code 4 is /16, code 7 /4096.
// - Reset clears every mode control bit.
// - Run bit set counts; run bit clear zeroes and holds the counter.
// - Mode bit: 0 clears and restarts on match, 1 is free-running PWM.
// - Set/clear written 0/1 clears flip-flop, 1/0 sets, 0/0 no change.
// - Bit 1 enables inversion outside PWM, selects active-low pulse in PWM.
// - Output enable 1 drives the pin from timer, 0 holds it low.
// - Set and clear bits are write-only and read back as zero.
// - Set and clear writes act only outside PWM mode.
// - In PWM mode clearing run forces the output inactive.
// - Mode, flip-flop, polarity and enable settings reach the pin regardless of run.
// - Both registers accept single-bit and whole-byte writes.
// - Counter clears on reset, on run clear, and on match in restart mode.
// - Outside PWM, counter equal to compare raises the match interrupt.
// - In PWM mode a match makes the output inactive without interrupt.
`timescale 1ns/1ps
`default_nettype none

module ebt_timer_ctrl #(
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // CPU memory access port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic cpu_bit_op,
  input wire logic [2:0] cpu_bit_sel,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // Compare values from the compare registers
  input wire logic [NUM_CH-1:0][7:0] compare_value,
  // Timer pins and events
  input wire logic [NUM_CH-1:0] event_in_pin,
  output logic [NUM_CH-1:0] timer_out_pin,
  output logic [NUM_CH-1:0] match_interrupt,
  output logic [NUM_CH-1:0][7:0] counter_value
);
  import ebt_pkg::*;

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] cs_addr(input int idx);
    cs_addr = (idx == 0) ? EBT_ADDR_T0_CLOCK_SELECT : EBT_ADDR_T1_CLOCK_SELECT;
  endfunction

  function automatic logic [15:0] mc_addr(input int idx);
    mc_addr = (idx == 0) ? EBT_ADDR_T0_MODE_CTRL : EBT_ADDR_T1_MODE_CTRL;
  endfunction

  // Only codes 4 and 7 differ between channels.
  function automatic logic [3:0] div_exp(input logic [2:0] sel, input int idx);
    logic [3:0] e;
    e = EBT_DIV_EXP_C2;
    case (sel)
      3'h2: e = EBT_DIV_EXP_C2;
      3'h3: e = EBT_DIV_EXP_C3;
      3'h4: e = (idx == 0) ? EBT_T0_DIV_EXP_C4 : EBT_T1_DIV_EXP_C4;
      3'h5: e = EBT_DIV_EXP_C5;
      3'h6: e = EBT_DIV_EXP_C6;
      3'h7: e = (idx == 0) ? EBT_T0_DIV_EXP_C7 : EBT_T1_DIV_EXP_C7;
      default: e = EBT_DIV_EXP_C2;
    endcase
    div_exp = e;
  endfunction

  // Readable image of the mode control register.
  function automatic logic [7:0] mc_image(input ebt_chan_s c);
    logic [7:0] v;
    v = 8'h00;
    v[EBT_BIT_RUN] = c.run;
    v[EBT_BIT_PWM] = c.pwm;
    v[EBT_BIT_INV] = c.inv_pol;
    v[EBT_BIT_OE] = c.oe;
    mc_image = v;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  ebt_state_s state_q;
  ebt_state_s state_d;

  always_comb begin
    logic [7:0] wmask;
    logic [7:0] cur;
    logic [7:0] nv;
    logic [EBT_PSCL_W-1:0] dmask;
    logic [3:0] dexp;
    logic tick;
    logic cs_hit;
    logic mc_hit;
    logic [7:0] rd;
    ebt_chan_s c;
    wmask = 8'hff;
    cur = 8'h00;
    nv = 8'h00;
    dmask = '0;
    dexp = 4'h0;
    tick = 1'b0;
    cs_hit = 1'b0;
    mc_hit = 1'b0;
    rd = 8'h00;
    c = '0;
    state_d = state_q;

    // A bit access writes one lane of the current image, a byte access all.
    if (cpu_bit_op) begin
      wmask = 8'((9'h1) << cpu_bit_sel);
    end

    state_d.pscl = state_q.pscl + 1'b1;

    for (int i = 0; i < NUM_CH; i++) begin
      c = state_q.ch[i];
      cs_hit = (cpu_addr == cs_addr(i));
      mc_hit = (cpu_addr == mc_addr(i));

      // --------------------------------------------------------
      // Count enable from the selected source
      // --------------------------------------------------------
      // The pin passes two flip-flops; edges are taken from the second.
      c.ev_sync1 = event_in_pin[i];
      c.ev_sync2 = state_q.ch[i].ev_sync1;
      c.ev_prev = state_q.ch[i].ev_sync2;
      dexp = div_exp(state_q.ch[i].clk_sel, i);
      dmask = EBT_PSCL_W'((14'h1 << dexp) - 14'h1);
      case (state_q.ch[i].clk_sel)
        EBT_CS_EDGE_FALL: tick = state_q.ch[i].ev_prev & ~state_q.ch[i].ev_sync2;
        EBT_CS_EDGE_RISE: tick = ~state_q.ch[i].ev_prev & state_q.ch[i].ev_sync2;
        default: tick = ((state_q.pscl & dmask) == dmask);
      endcase

      // --------------------------------------------------------
      // Counter, match and waveform flip-flops
      // --------------------------------------------------------
      c.match_irq = 1'b0;
      if (!state_q.ch[i].run) begin
        c.count = EBT_RST_COUNT;
        c.pwm_ff = 1'b0;
      end else if (!state_q.ch[i].pwm) begin
        if (tick) begin
          if (state_q.ch[i].count == compare_value[i]) begin
            c.count = EBT_RST_COUNT;
            c.match_irq = 1'b1;
            if (state_q.ch[i].inv_pol) begin
              c.out_ff = ~state_q.ch[i].out_ff;
            end
          end else begin
            c.count = state_q.ch[i].count + 8'h01;
          end
        end
      end else begin
        if (tick) begin
          // Free-running: active from wrap to zero until the match.
          c.count = state_q.ch[i].count + 8'h01;
          if (state_q.ch[i].count == compare_value[i]) begin
            c.pwm_ff = 1'b0;
          end else if (state_q.ch[i].count == 8'hff) begin
            c.pwm_ff = 1'b1;
          end
        end
      end

      // --------------------------------------------------------
      // Register writes
      // --------------------------------------------------------
      if (cpu_wr && cs_hit) begin
        cur = {5'h00, state_q.ch[i].clk_sel};
        nv = (cur & ~wmask) | (cpu_wdata & wmask);
        // Only the select field is stored; upper bits always read zero.
        c.clk_sel = nv[EBT_CS_MSB:0];
      end
      if (cpu_wr && mc_hit) begin
        cur = mc_image(state_q.ch[i]);
        nv = (cur & ~wmask) | (cpu_wdata & wmask);
        c.run = nv[EBT_BIT_RUN];
        c.pwm = nv[EBT_BIT_PWM];
        c.inv_pol = nv[EBT_BIT_INV];
        c.oe = nv[EBT_BIT_OE];
        // Software sets these in their own write, so a match toggle in the
        // same cycle loses to the explicit level request.
        if (!state_q.ch[i].pwm) begin
          if (nv[EBT_BIT_SET] && !nv[EBT_BIT_CLR]) begin
            c.out_ff = 1'b1;
          end else if (!nv[EBT_BIT_SET] && nv[EBT_BIT_CLR]) begin
            c.out_ff = 1'b0;
          end
        end
        // Stopping the counter in the write cycle clears it at once.
        if (!nv[EBT_BIT_RUN]) begin
          c.count = EBT_RST_COUNT;
          c.pwm_ff = 1'b0;
        end
      end

      // --------------------------------------------------------
      // Output pin, from the settings just stored
      // --------------------------------------------------------
      if (!c.oe) begin
        c.tout = 1'b0;
      end else if (c.pwm) begin
        c.tout = c.pwm_ff ^ c.inv_pol;
      end else begin
        c.tout = c.out_ff;
      end

      // --------------------------------------------------------
      // Read data
      // --------------------------------------------------------
      if (cs_hit) begin
        rd = rd | {5'h00, state_q.ch[i].clk_sel};
      end
      if (mc_hit) begin
        rd = rd | mc_image(state_q.ch[i]);
      end

      state_d.ch[i] = c;
    end

    // Unmapped addresses read as zero.
    if (cpu_rd) begin
      state_d.rdata = rd;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign cpu_rdata = state_q.rdata;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_out
    assign timer_out_pin[g] = state_q.ch[g].tout;
    assign match_interrupt[g] = state_q.ch[g].match_irq;
    assign counter_value[g] = state_q.ch[g].count;
  end

endmodule // ebt_timer_ctrl

`default_nettype wire

// *** verif/ebt_timer_ctrl_monitor.sv ***
// Port-level assertion checker for the two-channel timer control block.
`timescale 1ns/1ps
`default_nettype none

module ebt_timer_ctrl_monitor
  import ebt_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // CPU access port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic cpu_bit_op,
  input wire logic [2:0] cpu_bit_sel,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  // Timer side
  input wire logic [NUM_CH-1:0][7:0] compare_value,
  input wire logic [NUM_CH-1:0] event_in_pin,
  input wire logic [NUM_CH-1:0] timer_out_pin,
  input wire logic [NUM_CH-1:0] match_interrupt,
  input wire logic [NUM_CH-1:0][7:0] counter_value
);
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------
  // Mirror of channel 0 mode and enable bits
  // ------------------------------------------------------------
  // The pin and interrupt can only be judged against the stored mode.
  logic m_wr;
  logic pwm_q;
  logic oe_q;
  assign m_wr = cpu_wr && cpu_addr == EBT_ADDR_T0_MODE_CTRL;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (m_wr) begin
      if (!cpu_bit_op || cpu_bit_sel == 3'h6) begin
        pwm_q <= cpu_wdata[6];
      end
      if (!cpu_bit_op || cpu_bit_sel == 3'h0) begin
        oe_q <= cpu_wdata[0];
      end
    end
  end

  a_run_clear_zero: assert property (
    m_wr && !cpu_wdata[7] && (!cpu_bit_op || cpu_bit_sel == 3'h7) |=> counter_value[0] == 8'h00)
    else $error("counter not cleared by stop");
  a_count_step: assert property (
    counter_value[0] != $past(counter_value[0]) |-> counter_value[0] == 8'h00 ||
    counter_value[0] == $past(counter_value[0]) + 8'h01)
    else $error("counter moved by other than one");
  a_irq_cause: assert property (
    match_interrupt[0] |-> $past(counter_value[0]) == $past(compare_value[0]))
    else $error("interrupt without a compare match");
  a_pwm_no_irq: assert property (
    pwm_q && $past(pwm_q) |-> !match_interrupt[0])
    else $error("interrupt raised in pulse width mode");
  a_oe_low: assert property (
    !oe_q && $past(!oe_q) |-> timer_out_pin[0] == 1'b0)
    else $error("timer pin high while output disabled");
  a_wo_bits_zero: assert property (
    cpu_rd && cpu_addr == EBT_ADDR_T0_MODE_CTRL |=> cpu_rdata[5:2] == 4'h0)
    else $error("write-only mode bits read nonzero");
  a_sel_upper_zero: assert property (
    cpu_rd && (cpu_addr == EBT_ADDR_T0_CLOCK_SELECT || cpu_addr == EBT_ADDR_T1_CLOCK_SELECT)
    |=> cpu_rdata[7:3] == 5'h00)
    else $error("clock select upper bits read nonzero");
  a_sel_readback: assert property (
    cpu_wr && !cpu_bit_op && cpu_addr == EBT_ADDR_T0_CLOCK_SELECT ##1
    cpu_rd && cpu_addr == EBT_ADDR_T0_CLOCK_SELECT |=> cpu_rdata[2:0] == $past(cpu_wdata[2:0], 2))
    else $error("clock select read back differs");
endmodule // ebt_timer_ctrl_monitor

bind ebt_timer_ctrl ebt_timer_ctrl_monitor #(.NUM_CH(NUM_CH)) i_ebt_timer_ctrl_monitor (
  .core_clk(core_clk), .rstn(rstn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
  .cpu_bit_op(cpu_bit_op), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata),
  .cpu_rdata(cpu_rdata), .compare_value(compare_value), .event_in_pin(event_in_pin),
  .timer_out_pin(timer_out_pin), .match_interrupt(match_interrupt),
  .counter_value(counter_value));

`default_nettype wire

// *** verif/ebt_timer_ctrl_tb.sv ***
// Self-checking testbench of the two-channel timer control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (a), (e)); end end

module ebt_timer_ctrl_tb;
  import ebt_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic cpu_bit_op = 1'b0;
  logic [2:0] cpu_bit_sel = 3'h0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic [1:0][7:0] compare_value = '0;
  logic [1:0] event_in_pin = 2'h0;
  logic [1:0] timer_out_pin;
  logic [1:0] match_interrupt;
  logic [1:0][7:0] counter_value;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] cs_a [2] = '{EBT_ADDR_T0_CLOCK_SELECT, EBT_ADDR_T1_CLOCK_SELECT};
  logic [15:0] md_a [2] = '{EBT_ADDR_T0_MODE_CTRL, EBT_ADDR_T1_MODE_CTRL};
  int exps [2][8] = '{'{0, 0, 0, 1, 2, 6, 8, 13}, '{0, 0, 0, 1, 4, 6, 8, 12}};
  logic [7:0] wd [10] = '{8'h08, 8'h01, 8'h05, 8'h0d, 8'h09, 8'h01, 8'h41, 8'h43, 8'h47, 8'h01};
  logic pe [10] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

  ebt_timer_ctrl #(.NUM_CH(2)) i_ebt_timer_ctrl (
    .core_clk(core_clk), .rstn(rstn), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_bit_op(cpu_bit_op), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .compare_value(compare_value), .event_in_pin(event_in_pin),
    .timer_out_pin(timer_out_pin), .match_interrupt(match_interrupt),
    .counter_value(counter_value));

  always #5 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  // Tasks start at a falling edge and leave the strobe up, so back-to-back
  // accesses never assign one strobe twice in a time step.
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic b,
                     input logic [2:0] s);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_bit_op = b;
    cpu_bit_sel = s;
    cpu_wr = 1'b1;
    cpu_rd = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    cpu_addr = a;
    cpu_rd = 1'b1;
    cpu_wr = 1'b0;
    @(negedge core_clk);
    `CHK(cpu_rdata, e)
  endtask

  task automatic idle();
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic meas(input int c, input int e);
    int k;
    for (k = 0; k < 20000 && match_interrupt[c] !== 1'b1; k++) @(negedge core_clk);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (match_interrupt[c] !== 1'b1 && k < 20000);
    `CHK(k, e)
  endtask

  task automatic edge_chk(input int c, input logic v, input logic [7:0] e);
    event_in_pin[c] = v;
    repeat (8) @(negedge core_clk);
    `CHK(counter_value[c], e)
  endtask

  task automatic at_cnt(input logic [7:0] v, input logic e);
    for (int k = 0; k < 600 && counter_value[0] !== v; k++) @(negedge core_clk);
    `CHK(timer_out_pin[0], e)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The whole run needs about 26000 cycles; the ceiling leaves room.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    for (int c = 0; c < 2; c++) begin
      rd(cs_a[c], 8'h00);
      rd(md_a[c], 8'h00);
    end
    rd(16'h0000, 8'h00);
    $display("reset test done");
    for (int c = 0; c < 2; c++) begin
      for (int s = 2; s < 8; s++) begin
        acc(cs_a[c], 8'(s), 1'b0, 3'h0);
        rd(cs_a[c], 8'(s));
        acc(md_a[c], 8'h80, 1'b1, 3'h7);
        idle();
        meas(c, 1 << exps[c][s]);
        acc(md_a[c], 8'h00, 1'b0, 3'h0);
      end
    end
    $display("count clock test done");
    for (int c = 0; c < 2; c++) begin
      compare_value[c] = 8'hff;
      acc(cs_a[c], 8'h00, 1'b0, 3'h0);
      for (int s = 0; s < 2; s++) begin
        acc(md_a[c], 8'h80, 1'b1, 3'h7);
        idle();
        edge_chk(c, 1'b1, 8'(s));
        edge_chk(c, 1'b0, 8'h01);
        acc(md_a[c], 8'h00, 1'b0, 3'h0);
        `CHK(counter_value[c], 8'h00)
        acc(cs_a[c], 8'h01, 1'b1, 3'h0);
      end
      for (int i = 0; i < 10; i++) begin
        acc(md_a[c], wd[i], 1'b0, 3'h0);
        `CHK(timer_out_pin[c], pe[i])
        rd(md_a[c], wd[i] & 8'hf3);
      end
    end
    $display("event and output test done");
    compare_value[0] = 8'h03;
    acc(cs_a[0], 8'h02, 1'b0, 3'h0);
    acc(md_a[0], 8'h03, 1'b0, 3'h0);
    acc(md_a[0], 8'h80, 1'b1, 3'h7);
    idle();
    meas(0, 4);
    `CHK(timer_out_pin[0], 1'b1)
    repeat (4) @(negedge core_clk);
    `CHK(timer_out_pin[0], 1'b0)
    acc(md_a[0], 8'h00, 1'b1, 3'h7);
    `CHK(counter_value[0], 8'h00)
    $display("interval test done");
    compare_value[0] = 8'h80;
    acc(cs_a[0], 8'h02, 1'b0, 3'h0);
    acc(md_a[0], 8'h41, 1'b0, 3'h0);
    acc(md_a[0], 8'h80, 1'b1, 3'h7);
    idle();
    // The pulse only turns active at the first wrap after the start.
    at_cnt(8'h40, 1'b0);
    for (int p = 0; p < 2; p++) begin
      acc(md_a[0], 8'(p << 1), 1'b1, 3'h1);
      idle();
      at_cnt(8'h40, ~p[0]);
      at_cnt(8'hc0, p[0]);
    end
    at_cnt(8'h40, 1'b0);
    acc(md_a[0], 8'h00, 1'b1, 3'h7);
    `CHK(timer_out_pin[0], 1'b1)
    idle();
    $display("pulse width test done");
    tally_and_finish();
  end
endmodule // ebt_timer_ctrl_tb

`default_nettype wire
